// ### urx_receiver.sv
// Asynchronous serial receiver with two-deep buffer, error flags and APB register access.
`timescale 1ns/1ps
`include "urx_cfg.svh"

module urx_receiver (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`URX_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxdPin,
  input wire logic globalIrqEnable,
  output logic rxPinOverride,
  output logic rxCompleteIrq
);
  import urx_pkg::*;

  function automatic logic majority3(input logic [2:0] s);
    majority3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  // Control registers.
  logic rxEnable_q;
  logic rxcIrqEn_q;
  logic doubleSpeed_q;
  logic parityEn_q;
  logic parityOdd_q;
  logic stopTwo_q;
  logic [1:0] charSize_q;
  logic [11:0] baudDiv_q;

  // Bus slave state.
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [31:0] readData;
  logic addrHit;

  // Line synchroniser and recovery state.
  logic rxdMeta_q;
  logic rxdSync_q;
  logic lineHigh_q;
  logic [11:0] baudCnt_q;
  urx_state_t state_q;
  logic [4:0] sampleCnt_q;
  logic [1:0] votes_q;
  logic [3:0] bitCnt_q;
  logic [7:0] shift_q;
  logic parityBit_q;

  // Waiting frame and buffer.
  urx_entry_t hold_q;
  logic holdFull_q;
  logic overrunPend_q;
  urx_entry_t fifo_q [2];
  logic wrPtr_q;
  logic rdPtr_q;
  logic [1:0] count_q;
  logic rxcIrq_q;
  logic pinOverride_q;

  wire logic apbAccess = psel & penable;
  wire logic apbDone = apbAccess & pready_q;
  wire logic wrDone = apbDone & pwrite & ~pslverr_q;
  wire logic rdDone = apbDone & ~pwrite;
  wire logic rxComplete = (count_q != 2'h0);
  urx_entry_t head;
  assign head = fifo_q[rdPtr_q];

  wire logic [4:0] samplesPerBit = doubleSpeed_q ? `URX_SPB_DOUBLE : `URX_SPB_NORMAL;
  wire logic [4:0] voteFirst = doubleSpeed_q ? `URX_VOTE_DOUBLE : `URX_VOTE_NORMAL;
  wire logic [4:0] voteLast = voteFirst + 5'h02;
  wire logic [3:0] dataBits = `URX_MIN_BITS + {2'b00, charSize_q};
  wire logic sampleTick = (baudCnt_q == baudDiv_q);
  wire logic voteNow = sampleTick & (state_q != URX_IDLE) & (sampleCnt_q == voteLast);
  wire logic bitValue = majority3({votes_q, rxdSync_q});
  wire logic startOk = voteNow & (state_q == URX_START) & ~bitValue;
  wire logic frameDone = voteNow & (state_q == URX_STOP);
  wire logic fifoFull = (count_q == 2'h2);
  wire logic overrunHit = startOk & fifoFull & holdFull_q;
  wire logic popReq = rdDone & (paddr == `URX_OFF_DATA) & rxComplete;
  wire logic xfer = holdFull_q & ~fifoFull;

  // Short frames arrive LSB first into the top, so shifting down zero-fills the top bits.
  logic [7:0] frameData;
  assign frameData = shift_q >> (4'h8 - dataBits);

  urx_entry_t frameEntry;
  always_comb begin
    frameEntry.data = frameData;
    frameEntry.frameError = ~bitValue;
    frameEntry.overrunFlag = 1'b0;
    // Even parity flags an error when data parity differs from the received bit.
    frameEntry.parityError = parityEn_q & ((^frameData ^ parityOdd_q) != parityBit_q);
  end

  always_comb begin
    readData = 32'h0000_0000;
    addrHit = 1'b1;
    if (paddr == `URX_OFF_DATA) begin
      readData[7:0] = rxComplete ? head.data : 8'h00;
    end else if (paddr == `URX_OFF_CSA) begin
      readData[`URX_CSA_RXC] = rxComplete;
      readData[`URX_CSA_FE] = rxComplete & head.frameError;
      readData[`URX_CSA_DOR] = rxComplete & head.overrunFlag;
      readData[`URX_CSA_PE] = rxComplete & head.parityError;
      readData[`URX_CSA_U2X] = doubleSpeed_q;
    end else if (paddr == `URX_OFF_CSB) begin
      readData[`URX_CSB_RX_COMPLETE_IRQ_ENABLE] = rxcIrqEn_q;
      readData[`URX_CSB_RX_ENABLE] = rxEnable_q;
    end else if (paddr == `URX_OFF_CSC) begin
      readData[`URX_CSC_PEN] = parityEn_q;
      readData[`URX_CSC_PODD] = parityOdd_q;
      readData[`URX_CSC_SBS] = stopTwo_q;
      readData[`URX_CSC_SIZE_HI:`URX_CSC_SIZE_LO] = charSize_q;
    end else if (paddr == `URX_OFF_BAUD) begin
      readData[11:0] = baudDiv_q;
    end else begin
      addrHit = 1'b0;
    end
  end

  // One wait state keeps every bus output registered.
  always_ff @(posedge clk) begin
    if (rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= apbAccess & ~pready_q;
      if (apbAccess & ~pready_q) begin
        pslverr_q <= ~addrHit;
        prdata_q <= pwrite ? 32'h0000_0000 : readData;
      end else begin
        pslverr_q <= 1'b0;
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rxEnable_q <= 1'b0;
      rxcIrqEn_q <= 1'b0;
      doubleSpeed_q <= 1'b0;
      parityEn_q <= 1'b0;
      parityOdd_q <= 1'b0;
      stopTwo_q <= 1'b0;
      charSize_q <= `URX_RST_SIZE;
      baudDiv_q <= `URX_RST_BAUD;
    end else if (wrDone) begin
      if (paddr == `URX_OFF_CSA) begin
        doubleSpeed_q <= pwdata[`URX_CSA_U2X];
      end else if (paddr == `URX_OFF_CSB) begin
        rxcIrqEn_q <= pwdata[`URX_CSB_RX_COMPLETE_IRQ_ENABLE];
        rxEnable_q <= pwdata[`URX_CSB_RX_ENABLE];
      end else if (paddr == `URX_OFF_CSC) begin
        parityEn_q <= pwdata[`URX_CSC_PEN];
        parityOdd_q <= pwdata[`URX_CSC_PODD];
        stopTwo_q <= pwdata[`URX_CSC_SBS];
        charSize_q <= pwdata[`URX_CSC_SIZE_HI:`URX_CSC_SIZE_LO];
      end else if (paddr == `URX_OFF_BAUD) begin
        baudDiv_q <= pwdata[11:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rxdMeta_q <= 1'b1;
      rxdSync_q <= 1'b1;
    end else begin
      rxdMeta_q <= rxdPin;
      rxdSync_q <= rxdMeta_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !rxEnable_q || sampleTick) begin
      baudCnt_q <= 12'h000;
    end else begin
      baudCnt_q <= baudCnt_q + 12'h001;
    end
  end

  // Recovery runs only on sample ticks; a disable drops the frame in progress.
  always_ff @(posedge clk) begin
    if (rst || !rxEnable_q) begin
      state_q <= URX_IDLE;
      sampleCnt_q <= 5'h00;
      votes_q <= 2'h0;
      bitCnt_q <= 4'h0;
      shift_q <= 8'h00;
      parityBit_q <= 1'b0;
      // Starting low keeps a line already low at enable from faking a start.
      lineHigh_q <= 1'b0;
    end else if (sampleTick) begin
      lineHigh_q <= rxdSync_q;
      if (state_q == URX_IDLE) begin
        if (lineHigh_q && !rxdSync_q) begin
          state_q <= URX_START;
          sampleCnt_q <= 5'h02;
        end
      end else begin
        sampleCnt_q <= (sampleCnt_q == samplesPerBit) ? 5'h01 : sampleCnt_q + 5'h01;
        if (sampleCnt_q >= voteFirst && sampleCnt_q < voteLast) begin
          votes_q <= {votes_q[0], rxdSync_q};
        end
        if (sampleCnt_q == voteLast) begin
          case (state_q)
            URX_START: begin
              if (bitValue) begin
                state_q <= URX_IDLE;
              end else begin
                state_q <= URX_DATA;
                bitCnt_q <= 4'h0;
              end
            end
            URX_DATA: begin
              shift_q <= {bitValue, shift_q[7:1]};
              bitCnt_q <= bitCnt_q + 4'h1;
              if (bitCnt_q == dataBits - 4'h1) begin
                state_q <= parityEn_q ? URX_PARITY : URX_STOP;
              end
            end
            URX_PARITY: begin
              parityBit_q <= bitValue;
              state_q <= URX_STOP;
            end
            default: begin
              state_q <= URX_IDLE;
            end
          endcase
        end
      end
    end
  end

  // The finished frame waits here while the buffer is full.
  always_ff @(posedge clk) begin
    if (rst || !rxEnable_q) begin
      holdFull_q <= 1'b0;
      overrunPend_q <= 1'b0;
      hold_q <= '0;
    end else begin
      if (frameDone) begin
        holdFull_q <= 1'b1;
        hold_q <= frameEntry;
      end else if (overrunHit || xfer) begin
        holdFull_q <= 1'b0;
      end
      if (overrunHit) begin
        overrunPend_q <= 1'b1;
      end else if (xfer) begin
        overrunPend_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (xfer) begin
      fifo_q[wrPtr_q] <= '{data: hold_q.data, frameError: hold_q.frameError,
                           overrunFlag: overrunPend_q, parityError: hold_q.parityError};
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !rxEnable_q) begin
      wrPtr_q <= 1'b0;
      rdPtr_q <= 1'b0;
      count_q <= 2'h0;
    end else begin
      if (xfer) begin
        wrPtr_q <= ~wrPtr_q;
      end
      if (popReq) begin
        rdPtr_q <= ~rdPtr_q;
      end
      count_q <= count_q + {1'b0, xfer} - {1'b0, popReq};
    end
  end

  // Only the unread-data level reaches the request line; error flags never do.
  always_ff @(posedge clk) begin
    if (rst) begin
      rxcIrq_q <= 1'b0;
      pinOverride_q <= 1'b0;
    end else begin
      rxcIrq_q <= rxComplete & rxcIrqEn_q & globalIrqEnable;
      pinOverride_q <= rxEnable_q;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign rxCompleteIrq = rxcIrq_q;
  assign rxPinOverride = pinOverride_q;

endmodule // urx_receiver

// ### urx_cfg.svh
// Register offsets, field positions, reset values and timing counts of the receiver.
`ifndef URX_CFG_SVH
`define URX_CFG_SVH

`define URX_ADDR_W 12
`define URX_OFF_DATA 12'h000
`define URX_OFF_CSA 12'h004
`define URX_OFF_CSB 12'h008
`define URX_OFF_CSC 12'h00C
`define URX_OFF_BAUD 12'h010

`define URX_CSA_RXC 7
`define URX_CSA_FE 4
`define URX_CSA_DOR 3
`define URX_CSA_PE 2
`define URX_CSA_U2X 1
`define URX_CSB_RX_COMPLETE_IRQ_ENABLE 7
`define URX_CSB_RX_ENABLE 4
`define URX_CSC_PEN 5
`define URX_CSC_PODD 4
`define URX_CSC_SBS 3
`define URX_CSC_SIZE_LO 1
`define URX_CSC_SIZE_HI 2

`define URX_RST_BAUD 12'h000
`define URX_RST_SIZE 2'h3

`define URX_SPB_NORMAL 5'h10
`define URX_SPB_DOUBLE 5'h08
`define URX_VOTE_NORMAL 5'h08
`define URX_VOTE_DOUBLE 5'h04
`define URX_MIN_BITS 4'h5

`endif

// ### urx_pkg.sv
// Types shared by the receiver: recovery states and one buffered frame.
package urx_pkg;

  typedef enum logic [2:0] {
    URX_IDLE,
    URX_START,
    URX_DATA,
    URX_PARITY,
    URX_STOP
  } urx_state_t;

  typedef struct packed {
    logic [7:0] data;
    logic frameError;
    logic overrunFlag;
    logic parityError;
  } urx_entry_t;

endpackage

// ### urx_checker_asserts.sv
// Concurrent checks on the receiver's bus and interrupt ports.
`timescale 1ns/1ps
`include "urx_cfg.svh"

module urx_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`URX_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rxdPin,
  input wire logic globalIrqEnable,
  input wire logic rxPinOverride,
  input wire logic rxCompleteIrq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire wrB = psel && penable && pready && pwrite && paddr == `URX_OFF_CSB;
  wire rdA = pready && !pwrite && paddr == `URX_OFF_CSA;
  wire rdD = pready && !pwrite && paddr == `URX_OFF_DATA;

  pready_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("pready not one cycle after access");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  pslverr_pair_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  idle_rdata_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer cycle");
  pin_follow_a: assert property (
    wrB |=> ##1 rxPinOverride == $past(pwdata[`URX_CSB_RX_ENABLE], 2))
    else $error("pin override does not follow enable");
  // The flush lands one clock after the enable drops, and the request one clock later still.
  flush_irq_a: assert property (wrB && !pwdata[`URX_CSB_RX_ENABLE] |=> ##2 !rxCompleteIrq)
    else $error("interrupt kept after disable");
  mask_irq_a: assert property (wrB && !pwdata[`URX_CSB_RX_COMPLETE_IRQ_ENABLE] |=> ##1 !rxCompleteIrq)
    else $error("interrupt kept after mask");
  gie_gate_a: assert property (rxCompleteIrq |-> $past(globalIrqEnable))
    else $error("interrupt without global enable");
  empty_flags_a: assert property (rdA && !prdata[`URX_CSA_RXC] |-> prdata[4:2] == 3'h0)
    else $error("error flags shown with empty buffer");
  data_high_a: assert property (rdD |-> prdata[31:8] == 24'h0)
    else $error("data high bits not zero");
endmodule // urx_checker

bind urx_receiver urx_checker urx_checker_inst (
  .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .rxdPin, .globalIrqEnable, .rxPinOverride, .rxCompleteIrq
);

// ### urx_line_model.sv
// Remote serial transmitter model driving the receive line.
`timescale 1ns/1ps

module urx_line_model (
  input wire logic clk,
  output logic line
);
  initial line = 1'b1;

  // Bits after the start go LSB first, the last one being the stop bit.
  // A short stop length lets the next start fall right after the vote samples.
  task automatic send(input logic [10:0] bits, input int n, input int bt, input int sl);
    line <= 1'b0;
    repeat (bt) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      line <= bits[i];
      repeat (i == n - 1 ? sl : bt) @(posedge clk);
    end
    if (!bits[n-1]) line <= 1'b1;
  endtask

  task automatic glitch(input int len);
    line <= 1'b0;
    repeat (len) @(posedge clk);
    line <= 1'b1;
  endtask
endmodule // urx_line_model

// ### uart_receiver_status_recovery_tb.sv
// Register-level testbench of the serial receiver.
`timescale 1ns/1ps
`include "urx_cfg.svh"

module uart_receiver_status_recovery_tb;
  localparam logic [11:0] aDat = `URX_OFF_DATA;
  localparam logic [11:0] aCsa = `URX_OFF_CSA;
  localparam logic [11:0] aCsb = `URX_OFF_CSB;
  localparam logic [11:0] aCsc = `URX_OFF_CSC;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, gie = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, rxd, pinOvr, irq, e;
  int num_errors = 0, n_compared = 0, cyc = 0;

  initial forever #12.5 clk = ~clk;

  urx_line_model urx_line_model_inst (.clk, .line(rxd));
  urx_receiver urx_receiver_inst (
    .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .rxdPin(rxd), .globalIrqEnable(gie), .rxPinOverride(pinOvr),
    .rxCompleteIrq(irq)
  );

  task automatic tally_and_finish();
    if (num_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // An idle edge after each transfer keeps back-to-back calls from driving twice.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask

  task automatic frame(input logic [10:0] bits, input int n, input int bt, input int sl);
    urx_line_model_inst.send(bits, n, bt, sl);
    repeat (6) @(posedge clk);
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(aCsc, 32'h6);
    rd(aCsb, 32'h0);
    apb(1'b1, aCsb, 32'h90);
    // The override follows the enable one clock after the write lands.
    @(posedge clk);
    chk({31'h0, pinOvr}, 32'h1);
    frame(11'h1A5, 9, 16, 16);
    rd(aCsa, 32'h80);
    chk({31'h0, irq}, 32'h1);
    gie <= 1'b0;
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    gie <= 1'b1;
    rd(aDat, 32'hA5);
    rd(aCsa, 32'h0);
    frame(11'h03C, 9, 16, 16);
    apb(1'b1, aCsa, 32'h1C);
    rd(aCsa, 32'h90);
    rd(aDat, 32'h3C);
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, aCsc, k ? 32'h36 : 32'h26);
      frame(11'h201, 10, 16, 16);
      rd(aCsa, k ? 32'h80 : 32'h84);
      rd(aDat, 32'h1);
    end
    apb(1'b1, aCsc, 32'h6);
    for (int i = 1; i < 5; i++) urx_line_model_inst.send(11'h100 | 11'(i * 17), 9, 16, 10);
    repeat (6) @(posedge clk);
    rd(aCsa, 32'h80);
    rd(aDat, 32'h11);
    rd(aCsa, 32'h80);
    rd(aDat, 32'h22);
    rd(aCsa, 32'h88);
    rd(aDat, 32'h44);
    rd(aCsa, 32'h0);
    apb(1'b1, aCsc, 32'h0);
    apb(1'b1, aCsa, 32'h2);
    urx_line_model_inst.glitch(2);
    repeat (30) @(posedge clk);
    rd(aCsa, 32'h2);
    frame(11'h035, 6, 8, 8);
    rd(aCsa, 32'h82);
    rd(aDat, 32'h15);
    apb(1'b1, aCsa, 32'h0);
    apb(1'b1, aCsc, 32'h6);
    frame(11'h1A5, 9, 16, 16);
    apb(1'b1, aCsb, 32'h80);
    rd(aCsa, 32'h0);
    chk({31'h0, pinOvr}, 32'h0);
    apb(1'b1, aCsb, 32'h90);
    fork
      urx_line_model_inst.send(11'h1A5, 9, 16, 16);
      begin
        repeat (50) @(posedge clk);
        apb(1'b1, aCsb, 32'h0);
      end
    join
    apb(1'b1, aCsb, 32'h90);
    rd(aCsa, 32'h0);
    apb(1'b0, 12'hFFC, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    tally_and_finish();
  end
endmodule // uart_receiver_status_recovery_tb
